/* design/rtc_watch_error_correction.sv */
`default_nettype none

module rtc_watch_error_correction (
  input  wire  logic                                ref_clk,
  input  wire  logic                                srst,
  input  wire  logic                                psel,
  input  wire  logic                                penable,
  input  wire  logic                                pwrite,
  input  wire  logic [rtc_corr_pkg::ADDR_W-1:0]     paddr,
  input  wire  logic [rtc_corr_pkg::DATA_W-1:0]     pwdata,
  output logic       [rtc_corr_pkg::DATA_W-1:0]     prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire  logic                                subClkIn,
  output logic                                      oneHzOut,
  output logic                                      subClkOut
);

  rtc_corr_pkg::ctrl_t                      ctrl_ff;
  rtc_corr_pkg::ctrl_t                      nxt_ctrl;
  rtc_corr_pkg::corr_t                      corr_ff;
  rtc_corr_pkg::corr_t                      nxt_corr;
  rtc_corr_pkg::ctrl_t                      wrCtrl;
  logic [rtc_corr_pkg::DATA_W-1:0]          prdata_ff;
  logic [rtc_corr_pkg::DATA_W-1:0]          nxt_prdata;
  logic                                     pready_ff;
  logic                                     nxt_pready;
  logic                                     pslverr_ff;
  logic                                     nxt_pslverr;
  logic                                     access;
  logic                                     commit;
  logic                                     addrHit;
  logic [rtc_corr_pkg::DATA_W-1:0]          rdMux;

  logic [rtc_corr_pkg::SUB_CNT_W-1:0]       subCnt_ff;
  logic [rtc_corr_pkg::SUB_CNT_W-1:0]       nxt_subCnt;
  logic [rtc_corr_pkg::SEC_CNT_W-1:0]       secCnt_ff;
  logic [rtc_corr_pkg::SEC_CNT_W-1:0]       nxt_secCnt;
  logic                                     subDly_ff;
  logic                                     subRise;
  logic                                     run;
  logic                                     corrEn;
  logic signed [rtc_corr_pkg::CORR_VAL_W-1:0] corrVal;
  logic                                     applySlot;
  logic [rtc_corr_pkg::SUB_CNT_W-1:0]       corrExt;
  logic [rtc_corr_pkg::SUB_CNT_W-1:0]       curLimit;
  logic                                     wrap;

  logic                                     oneHz_ff;
  logic                                     nxt_oneHz;
  logic                                     clkOut_ff;
  logic                                     nxt_clkOut;
  logic                                     divBit;

  corr_value_decode u_decode (
    .corr    (corr_ff),
    .corrEn  (corrEn),
    .corrVal (corrVal)
  );

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign oneHzOut  = oneHz_ff;
  assign subClkOut = clkOut_ff;

  // Bus slave: one wait state, write lands on the pready edge
  always_comb begin
    access  = psel & penable & ~pready_ff;
    commit  = psel & penable & pready_ff & pwrite;
    addrHit = 1'b1;
    unique case (paddr)
      rtc_corr_pkg::ADDR_CTRL: begin
        rdMux = {{(rtc_corr_pkg::DATA_W - rtc_corr_pkg::CTRL_W){1'b0}},
                 ctrl_ff};
      end
      rtc_corr_pkg::ADDR_CORR: begin
        rdMux = {{(rtc_corr_pkg::DATA_W - rtc_corr_pkg::CORR_W){1'b0}},
                 corr_ff};
      end
      rtc_corr_pkg::ADDR_SUBCNT: begin
        rdMux = {{(rtc_corr_pkg::DATA_W - rtc_corr_pkg::SUB_CNT_W){1'b0}},
                 subCnt_ff};
      end
      rtc_corr_pkg::ADDR_SEC: begin
        rdMux = {{(rtc_corr_pkg::DATA_W - rtc_corr_pkg::SEC_CNT_W){1'b0}},
                 secCnt_ff};
      end
      default: begin
        rdMux   = 32'h0000_0000;
        addrHit = 1'b0;
      end
    endcase
    nxt_pready  = access;
    nxt_prdata  = access ? rdMux : prdata_ff;
    nxt_pslverr = access & ~addrHit;
  end

  // Register writes
  always_comb begin
    wrCtrl   = rtc_corr_pkg::ctrl_t'(pwdata[rtc_corr_pkg::CTRL_W-1:0]);
    nxt_ctrl = ctrl_ff;
    nxt_corr = corr_ff;
    if (commit && paddr == rtc_corr_pkg::ADDR_CTRL) begin
      nxt_ctrl = wrCtrl;
      // Output select frozen while running to avoid glitching the pin
      if (ctrl_ff.counterRunEnable) begin
        nxt_ctrl.clkSel = ctrl_ff.clkSel;
      end
    end
    if (commit && paddr == rtc_corr_pkg::ADDR_CORR) begin
      nxt_corr = rtc_corr_pkg::corr_t'(pwdata[rtc_corr_pkg::CORR_W-1:0]);
    end
  end

  // Sub-second and second counters
  always_comb begin
    run     = ctrl_ff.counterRunEnable;
    subRise = subClkIn & ~subDly_ff;
    if (corr_ff.correctionIntervalSelect) begin
      applySlot = secCnt_ff == rtc_corr_pkg::SEC_LAST;
    end else begin
      applySlot = secCnt_ff == rtc_corr_pkg::SEC_MARK_A ||
                  secCnt_ff == rtc_corr_pkg::SEC_MARK_B ||
                  secCnt_ff == rtc_corr_pkg::SEC_LAST;
    end
    corrExt = {{(rtc_corr_pkg::SUB_CNT_W - rtc_corr_pkg::CORR_VAL_W)
               {corrVal[rtc_corr_pkg::CORR_VAL_W-1]}}, corrVal};
    if (!(applySlot && corrEn)) begin
      corrExt = 17'h00000;
    end
    // Positive value lengthens the second, so time runs slower
    curLimit = rtc_corr_pkg::NOMINAL_LAST + corrExt;
    // Compare with >= so a shorter limit written mid-second cannot skip
    wrap = run & subRise & (subCnt_ff >= curLimit);
    nxt_subCnt = subCnt_ff;
    nxt_secCnt = secCnt_ff;
    if (run && subRise) begin
      nxt_subCnt = wrap ? 17'h00000 : subCnt_ff + 17'h00001;
    end
    if (wrap) begin
      nxt_secCnt = (secCnt_ff >= rtc_corr_pkg::SEC_LAST) ?
                   6'h00 : secCnt_ff + 6'h01;
    end
  end

  // Clock outputs follow the corrected counter, except subClkOut with select 0 or 3, which passes subClkIn
  always_comb begin
    unique case (ctrl_ff.clkSel)
      rtc_corr_pkg::CLK_SEL_16K: begin
        divBit = run & subCnt_ff[rtc_corr_pkg::DIV_16K_BIT];
      end
      rtc_corr_pkg::CLK_SEL_512: begin
        divBit = run & subCnt_ff[rtc_corr_pkg::DIV_512_BIT];
      end
      default: begin
        divBit = subClkIn;
      end
    endcase
    nxt_clkOut = ctrl_ff.clkOutEn & divBit;
    nxt_oneHz  = run & ctrl_ff.oneHzEn &
                 (subCnt_ff < rtc_corr_pkg::HALF_SEC);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_ff    <= rtc_corr_pkg::CTRL_RST;
      corr_ff    <= rtc_corr_pkg::CORR_RST;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      subCnt_ff  <= 17'h00000;
      secCnt_ff  <= 6'h00;
      subDly_ff  <= 1'b0;
      oneHz_ff   <= 1'b0;
      clkOut_ff  <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      corr_ff    <= nxt_corr;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      subCnt_ff  <= nxt_subCnt;
      secCnt_ff  <= nxt_secCnt;
      subDly_ff  <= subClkIn;
      oneHz_ff   <= nxt_oneHz;
      clkOut_ff  <= nxt_clkOut;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  AST_WRAP_CLEARS: assert property (
    wrap |=> subCnt_ff == 17'h00000 &&
             secCnt_ff == $past(nxt_secCnt))
    else $error("Counter did not restart after full second");

  AST_STOP_HOLDS: assert property (
    !run |=> $stable(subCnt_ff) && $stable(secCnt_ff))
    else $error("Counter moved while stopped");

  AST_ONCE_PER_MIN: assert property (
    corr_ff.correctionIntervalSelect &&
    secCnt_ff != rtc_corr_pkg::SEC_LAST
    |-> curLimit == rtc_corr_pkg::NOMINAL_LAST)
    else $error("Correction applied outside minute end");

  AST_THREE_PER_MIN: assert property (
    !corr_ff.correctionIntervalSelect && corrEn &&
    secCnt_ff == rtc_corr_pkg::SEC_MARK_B
    |-> curLimit == rtc_corr_pkg::NOMINAL_LAST +
        {{9{corrVal[7]}}, corrVal})
    else $error("Twenty second correction missing");

  AST_POS_FORMULA: assert property (
    corrEn && !corr_ff.correctionSign
    |-> corrVal == {1'b0, corr_ff.correctionMagnitude - 6'h01, 1'b0})
    else $error("Positive correction value wrong");

  AST_NEG_FORMULA: assert property (
    corrEn && corr_ff.correctionSign
    |-> corrVal + {1'b0, ~corr_ff.correctionMagnitude + 6'h01, 1'b0}
        == 8'h00)
    else $error("Negative correction value wrong");

  AST_ZERO_FIELD: assert property (
    corr_ff.correctionMagnitude[5:1] == 5'h00
    |-> curLimit == rtc_corr_pkg::NOMINAL_LAST)
    else $error("Correction made with empty field");

  AST_EVEN_RANGE: assert property (
    corrEn |-> !corrVal[0] && corrVal != 8'h00 &&
               corrVal <= 8'sh7C && corrVal >= -8'sh7C)
    else $error("Correction value not even or out of range");

  AST_SIGN_DIR: assert property (
    corrEn |-> (corrVal > 0) == !corr_ff.correctionSign)
    else $error("Correction direction wrong");

  AST_SEL_LOCK: assert property (
    run && commit && paddr == rtc_corr_pkg::ADDR_CTRL
    |=> ctrl_ff.clkSel == $past(ctrl_ff.clkSel))
    else $error("Output select changed while running");

  AST_ONE_HZ: assert property (
    run && ctrl_ff.oneHzEn
    |=> oneHzOut == ($past(subCnt_ff) < rtc_corr_pkg::HALF_SEC))
    else $error("One hertz output wrong");

  AST_APB_ANSWER: assert property (
    psel && !penable ##1 psel && penable
    |-> !pready ##1 pready)
    else $error("Bus answer not after one wait state");

  CVR_WRAP_CORR: cover property (wrap && applySlot && corrEn);
  CVR_NEG_CORR: cover property (wrap && corrEn && corr_ff.correctionSign);
  CVR_MIN_END: cover property (wrap && secCnt_ff == rtc_corr_pkg::SEC_LAST);
  CVR_BAD_ADDR: cover property (pslverr);

endmodule // rtc_watch_error_correction

`default_nettype wire

/* design/rtc_corr_pkg.sv */
`default_nettype none

package rtc_corr_pkg;

  localparam int SUB_CNT_W  = 17;
  localparam int SEC_CNT_W  = 6;
  localparam int CORR_VAL_W = 8;
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;

  localparam logic [SUB_CNT_W-1:0] NOMINAL_LAST = 17'h07FFF;
  localparam logic [SUB_CNT_W-1:0] HALF_SEC     = 17'h04000;
  localparam logic [SEC_CNT_W-1:0] SEC_LAST     = 6'h3B;
  localparam logic [SEC_CNT_W-1:0] SEC_MARK_A   = 6'h13;
  localparam logic [SEC_CNT_W-1:0] SEC_MARK_B   = 6'h27;

  localparam int DIV_16K_BIT = 0;
  localparam int DIV_512_BIT = 5;

  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CORR   = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_SUBCNT = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_SEC    = 12'h00C;

  localparam logic [1:0] CLK_SEL_SUB = 2'h0;
  localparam logic [1:0] CLK_SEL_16K = 2'h1;
  localparam logic [1:0] CLK_SEL_512 = 2'h2;

  typedef struct packed {
    logic [1:0] clkSel;
    logic       clkOutEn;
    logic       oneHzEn;
    logic       counterRunEnable;
  } ctrl_t;

  typedef struct packed {
    logic       correctionIntervalSelect;
    logic       correctionSign;
    logic [5:0] correctionMagnitude;
  } corr_t;

  localparam int CTRL_W = $bits(ctrl_t);
  localparam int CORR_W = $bits(corr_t);

  localparam ctrl_t CTRL_RST = 5'h00;
  localparam corr_t CORR_RST = 8'h00;

endpackage

`default_nettype wire

/* design/corr_value_decode.sv */
`default_nettype none

module corr_value_decode (
  input  wire  rtc_corr_pkg::corr_t                   corr,
  output logic                                        corrEn,
  output logic signed [rtc_corr_pkg::CORR_VAL_W-1:0] corrVal
);

  logic [rtc_corr_pkg::CORR_VAL_W-1:0] magSum;
  logic [rtc_corr_pkg::CORR_VAL_W-1:0] scaled;

  always_comb begin
    // Only bits 5 to 1 decide; bit 0 alone gives zero
    corrEn = |corr.correctionMagnitude[5:1];
    if (corr.correctionSign) begin
      magSum = {2'h0, ~corr.correctionMagnitude} + 8'h01;
    end else begin
      magSum = {2'h0, corr.correctionMagnitude} - 8'h01;
    end
    scaled = {magSum[rtc_corr_pkg::CORR_VAL_W-2:0], 1'b0};
    if (!corrEn) begin
      corrVal = 8'h00;
    end else if (corr.correctionSign) begin
      corrVal = -scaled;
    end else begin
      corrVal = scaled;
    end
  end

endmodule // corr_value_decode

`default_nettype wire

/* verification/rtc_watch_error_correction_test.sv */
`default_nettype none

module rtc_watch_error_correction_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        subClkIn;
  logic        oneHzOut;
  logic        subClkOut;
  int          numErrors;
  int          totalChecks;
  int          idx;
  logic [31:0] rdData;
  logic        rdErr;
  logic [31:0] corrTab [6];

  rtc_watch_error_correction dut (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .subClkIn  (subClkIn),
    .oneHzOut  (oneHzOut),
    .subClkOut (subClkOut)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Idle edge first, so a release and a new setup never share a step
  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [31:0] data);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      check("pready", {31'h0, pready}, 32'h1);
      close_out();
    end
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp,
                    input string what);
    apb(1'b0, addr, 32'h0);
    check(what, rdData, exp);
  endtask

  // One subsystem rise every two ref_clk cycles keeps the run short
  task automatic run_sub(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      subClkIn <= 1'b1;
      @(posedge ref_clk);
      subClkIn <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pins(input logic expOne, input logic expSub);
    repeat (3) @(posedge ref_clk);
    check("oneHzOut", {31'h0, oneHzOut}, {31'h0, expOne});
    check("subClkOut", {31'h0, subClkOut}, {31'h0, expSub});
  endtask

  initial begin
    srst     = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    subClkIn = 1'b0;
    // Table mixes interval select 0 and 1 with both signs
    corrTab  = '{32'h2C, 32'h6E, 32'hAC, 32'hC1, 32'h81, 32'hFFFFFFFF};
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    rd(rtc_corr_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
    rd(rtc_corr_pkg::ADDR_CORR, 32'h0, "corr reset");
    rd(rtc_corr_pkg::ADDR_SUBCNT, 32'h0, "subcount reset");
    rd(rtc_corr_pkg::ADDR_SEC, 32'h0, "seconds reset");
    pins(1'b0, 1'b0);
    for (idx = 0; idx < 6; idx++) begin
      apb(1'b1, rtc_corr_pkg::ADDR_CORR, corrTab[idx]);
      rd(rtc_corr_pkg::ADDR_CORR, corrTab[idx] & 32'hFF, "corr");
    end
    rd(12'h010, 32'h0, "unmapped data");
    check("unmapped err", {31'h0, rdErr}, 32'h1);
    apb(1'b1, rtc_corr_pkg::ADDR_SUBCNT, 32'h1234);
    rd(rtc_corr_pkg::ADDR_SUBCNT, 32'h0, "subcount read only");
    // Select 1, negative: only second 59 is shortened, second 0 is not
    apb(1'b1, rtc_corr_pkg::ADDR_CORR, 32'hEE);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h07);
    run_sub(16383);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h06);
    rd(rtc_corr_pkg::ADDR_SUBCNT, 32'h3FFF, "count steps");
    run_sub(2);
    rd(rtc_corr_pkg::ADDR_SUBCNT, 32'h3FFF, "count held");
    // Divided outputs are gated low while the counter is stopped
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h0E);
    pins(1'b0, 1'b0);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h0F);
    pins(1'b1, 1'b1);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h0E);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h16);
    pins(1'b0, 1'b0);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h17);
    pins(1'b1, 1'b1);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h16);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h1E);
    pins(1'b0, 1'b0);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h07);
    pins(1'b1, 1'b0);
    // Select change refused while running
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h0F);
    rd(rtc_corr_pkg::ADDR_CTRL, 32'h07, "ctrl sel kept");
    run_sub(1);
    pins(1'b0, 1'b0);
    rd(rtc_corr_pkg::ADDR_SUBCNT, 32'h4000, "half second");
    run_sub(16384);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h07);
    pins(1'b1, 1'b0);
    apb(1'b1, rtc_corr_pkg::ADDR_CTRL, 32'h06);
    rd(rtc_corr_pkg::ADDR_SUBCNT, 32'h0, "second wrap");
    rd(rtc_corr_pkg::ADDR_SEC, 32'h1, "seconds step");
    close_out();
  end

endmodule // rtc_watch_error_correction_test

`default_nettype wire
